// ---- rtl/mode_clock_consts.vh ----
// Constants for the operating-mode and system-clock controller.
// Assumes a register port with one-cycle read latency and 8-bit data.
`ifndef MODE_CLOCK_CONSTS_VH
`define MODE_CLOCK_CONSTS_VH

// ==========================================================================
// Register offsets
`define ADDR_SYSTEM_MODE_CONTROL 2'h0
`define ADDR_POWER_CONTROL_FLAGS 2'h1
`define ADDR_MODE_STATUS         2'h2

// ==========================================================================
// Field positions
`define SMC_CLKSEL_HI    7
`define SMC_CLKSEL_LO    5
`define SMC_LOW_READY    3
`define SMC_HIGH_READY   2
`define SMC_IDLE_EN      1
`define SMC_HIGH_SEL     0
`define PCF_SYSCLK_KEEP  7
`define PCF_LVD_EN       3
`define PCF_FLAGS_HI     2
`define MST_LVD_EN       0

// ==========================================================================
// Reset values
`define RST_CLKSEL       3'h6
`define RST_IDLE_EN      1'h1
`define RST_HIGH_SEL     1'h0
`define RST_SYSCLK_KEEP  1'h0
`define RST_FLAGS        3'h0
`define RST_LVD_EN       1'h0

// ==========================================================================
// Timing counts, in cycles of clk_in, which clocks both ready counters
`define HIGH_READY_CYCLES 5'h0F
`define LOW_READY_CYCLES  2'h1

`endif

// ---- rtl/osc_ready_counter.v ----
// Counts cycles after an oscillator enable and raises a ready flag.
// Assumes the enable is synchronous to clk_in.
`default_nettype none

module osc_ready_counter #(
  parameter [4:0] COUNT = 5'h0F
)(
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       run_in,
  output reg        ready_out
);

  reg [4:0] count_q;

  // The flag falls at once when the oscillator stops and rises COUNT cycles after it restarts.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_q   <= 5'h00;
      ready_out <= 1'b0;
    end
    else if (!run_in)
    begin
      count_q   <= 5'h00;
      ready_out <= 1'b0;
    end
    else if (count_q < COUNT)
    begin
      count_q   <= count_q + 5'h01;
      ready_out <= (count_q + 5'h01) >= COUNT;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/mode_clock_ctrl.v ----
// Operating-mode and system-clock controller: mode registers, halt handling,
// oscillator enables and ready flags, system clock divider selection.
// Assumes core halt and wake requests are one-cycle pulses synchronous to clk_in.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "mode_clock_consts.vh"
`default_nettype none

// Notes on behaviour
// [R01] A halt with idle_enable low enters sleep: CPU and system clock stop, sub clock runs, timebase clock stops.
// [R02] A halt with idle_enable high and idle_sysclk_keep low enters idle_clock_stopped_mode: CPU and high oscillator stop, sub and timebase clocks run.
// [R03] A halt with both bits high enters idle_clock_running_mode: CPU stops, the selected system clock and sub clock keep running.
// [R04] Sleep halts the CPU entirely while the sub clock oscillator keeps operating.
// [R05] With high_clock_select low, codes 000 and 001 give sub clock and 010 to 111 give high clock over 64 down to 2.
// [R06] With high_clock_select high the undivided high clock is the system clock.
// [R07] Switching the system clock from high clock to sub clock stops the high speed oscillator.
// [R08] While the high speed oscillator is stopped, its divided peripheral clock enables are stopped too.
// [R09] low_osc_ready stays low until the low oscillator is stable and then rises within 1 to 2 cycles.
// [R10] high_osc_ready clears at power-on, stays low in sleep and idle_clock_stopped_mode, and sets 15 to 16 cycles after restart.
// [R11] Unimplemented bit 4 of the mode register and bits 6 to 3 of the control register read as zero.
// [R12] With low_volt_detect_enable high in sleep or idle, the detector and bandgap stay on and sub clock is forced on.
// [R13] A switch to slow mode completes only once low_osc_ready is high.
// [R14] Software checks high_osc_ready before relying on the high clock after returning to normal mode.
// [R15] idle_enable and idle_sysclk_keep are sampled in the cycle the halt is accepted.
module mode_clock_ctrl (
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire [1:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  input  wire       halt_in,
  input  wire       wake_in,
  output reg  [7:0] rdata_out,
  output reg        cpu_run_out,
  output reg        sysclk_run_out,
  output reg        timebase_run_out,
  output reg        sub_osc_en_out,
  output reg        high_osc_en_out,
  output reg        high_div_en_out,
  output reg        sysclk_is_sub_out,
  output reg  [6:0] high_div_onehot_out,
  output reg        lvd_active_out
);

  // ==========================================================================
  // Modes
  localparam [2:0] MODE_NORMAL = 3'h0;
  localparam [2:0] MODE_SLOW   = 3'h1;
  localparam [2:0] MODE_SLEEP  = 3'h2;
  localparam [2:0] MODE_IDLE_CLOCK_STOPPED_MODE  = 3'h3;
  localparam [2:0] MODE_IDLE_CLOCK_RUNNING_MODE  = 3'h4;

  // ==========================================================================
  // Reset release
  reg        rst_meta_q;
  reg        rst_sync_q;

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  // ==========================================================================
  // Clock selection decode
  // Returns one-hot divider choice; bit 0 is undivided, bit 6 is divide by 64, zero means sub clock.
  function [6:0] div_decode;
    input       high_sel;
    input [2:0] code;
    begin
      div_decode = 7'h00;
      if (high_sel)
        div_decode = 7'h01;
      else if (code >= 3'h2)
        div_decode = 7'h01 << (3'h7 - code + 3'h1);
    end
  endfunction

  // Returns one for the modes in which the CPU is halted.
  function mode_halted;
    input [2:0] mode;
    begin
      case (mode)
        MODE_SLEEP,
        MODE_IDLE_CLOCK_STOPPED_MODE,
        MODE_IDLE_CLOCK_RUNNING_MODE:
          mode_halted = 1'b1;
        default:
          mode_halted = 1'b0;
      endcase
    end
  endfunction

  // Returns one for the modes in which the system clock is stopped.
  function mode_stops_sysclk;
    input [2:0] mode;
    begin
      case (mode)
        MODE_SLEEP,
        MODE_IDLE_CLOCK_STOPPED_MODE:
          mode_stops_sysclk = 1'b1;
        default:
          mode_stops_sysclk = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================================
  // Registers
  reg [2:0] clk_sel_q;
  reg       idle_enable_q;
  reg       high_clock_select_q;
  reg       idle_sysclk_keep_q;
  reg       low_volt_detect_enable_q;
  reg [2:0] reset_flags_q;
  reg [2:0] mode_q;
  reg [2:0] mode_d;
  reg       halt_idle_en_q;
  reg       halt_keep_q;
  reg       halt_pending_q;
  wire      low_osc_ready;
  wire      high_osc_ready;

  wire [6:0] want_div   = div_decode(high_clock_select_q, clk_sel_q);
  wire       want_sub   = (want_div == 7'h00);
  wire       halted     = mode_halted(mode_q);

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_sel_q                <= `RST_CLKSEL;
      idle_enable_q            <= `RST_IDLE_EN;
      high_clock_select_q      <= `RST_HIGH_SEL;
      idle_sysclk_keep_q       <= `RST_SYSCLK_KEEP;
      low_volt_detect_enable_q <= `RST_LVD_EN;
      reset_flags_q            <= `RST_FLAGS;
    end
    else if (wr_in && addr_in == `ADDR_SYSTEM_MODE_CONTROL)
    begin
      clk_sel_q           <= wdata_in[`SMC_CLKSEL_HI:`SMC_CLKSEL_LO];
      idle_enable_q       <= wdata_in[`SMC_IDLE_EN];
      high_clock_select_q <= wdata_in[`SMC_HIGH_SEL];
    end
    else if (wr_in && addr_in == `ADDR_POWER_CONTROL_FLAGS)
    begin
      idle_sysclk_keep_q <= wdata_in[`PCF_SYSCLK_KEEP];
      reset_flags_q      <= wdata_in[`PCF_FLAGS_HI:0];
    end
    else if (wr_in && addr_in == `ADDR_MODE_STATUS)
      low_volt_detect_enable_q <= wdata_in[`MST_LVD_EN];
  end

  // ==========================================================================
  // Mode machine
  always @*
  begin
    mode_d = mode_q;
    case (mode_q)
      MODE_NORMAL,
      MODE_SLOW:
      begin
        if (halt_pending_q)
        begin
          // [R01] [R02] [R03] halt mode choice
          if (!halt_idle_en_q)
            mode_d = MODE_SLEEP;
          else if (!halt_keep_q)
            mode_d = MODE_IDLE_CLOCK_STOPPED_MODE;
          else
            mode_d = MODE_IDLE_CLOCK_RUNNING_MODE;
        end
        // [R13] slow needs stable oscillator
        else if (want_sub && low_osc_ready)
          mode_d = MODE_SLOW;
        else if (!want_sub)
          mode_d = MODE_NORMAL;
      end
      MODE_SLEEP,
      MODE_IDLE_CLOCK_STOPPED_MODE,
      MODE_IDLE_CLOCK_RUNNING_MODE:
      begin
        if (wake_in)
          mode_d = want_sub ? MODE_SLOW : MODE_NORMAL;
      end
      default:
        mode_d = MODE_NORMAL;
    endcase
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q         <= MODE_NORMAL;
      halt_pending_q <= 1'b0;
      halt_idle_en_q <= 1'b0;
      halt_keep_q    <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      // [R15] sample idle bits at halt
      if (halt_in && !halted && !halt_pending_q)
      begin
        halt_pending_q <= 1'b1;
        halt_idle_en_q <= idle_enable_q;
        halt_keep_q    <= idle_sysclk_keep_q;
      end
      else if (halt_pending_q)
        halt_pending_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Oscillator control and ready flags
  // The high oscillator runs in normal mode, in idle_clock_running_mode when the system clock is high,
  // and in no other mode.
  reg high_osc_en_d;
  reg sysclk_is_sub_d;

  always @*
  begin
    high_osc_en_d   = 1'b0;
    sysclk_is_sub_d = 1'b0;
    case (mode_d)
      // [R07] stop high oscillator on sub
      MODE_NORMAL:
        high_osc_en_d = 1'b1;
      MODE_SLOW:
        sysclk_is_sub_d = 1'b1;
      MODE_IDLE_CLOCK_RUNNING_MODE:
      begin
        // [R03] keep source in idle_clock_running_mode
        if (mode_q == MODE_IDLE_CLOCK_RUNNING_MODE)
        begin
          high_osc_en_d   = high_osc_en_out;
          sysclk_is_sub_d = sysclk_is_sub_out;
        end
        else
        begin
          high_osc_en_d   = (mode_q == MODE_NORMAL);
          sysclk_is_sub_d = (mode_q == MODE_SLOW);
        end
      end
      default:
      begin
        high_osc_en_d   = 1'b0;
        sysclk_is_sub_d = 1'b0;
      end
    endcase
  end
  wire low_run  = 1'b1;

  // [R10] high ready after restart
  osc_ready_counter #(
    .COUNT (`HIGH_READY_CYCLES)
  ) u_high_ready (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n),
    .run_in    (high_osc_en_out),
    .ready_out (high_osc_ready)
  );

  // [R09] low ready after stable
  osc_ready_counter #(
    .COUNT ({3'h0, `LOW_READY_CYCLES})
  ) u_low_ready (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n),
    .run_in    (sub_osc_en_out),
    .ready_out (low_osc_ready)
  );

  // ==========================================================================
  // Clock enables
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_run_out         <= 1'b0;
      sysclk_run_out      <= 1'b0;
      timebase_run_out    <= 1'b0;
      sub_osc_en_out      <= 1'b0;
      high_osc_en_out     <= 1'b0;
      high_div_en_out     <= 1'b0;
      sysclk_is_sub_out   <= 1'b0;
      high_div_onehot_out <= 7'h00;
      lvd_active_out      <= 1'b0;
    end
    else
    begin
      // [R04] CPU off when halted
      cpu_run_out       <= !mode_halted(mode_d);
      // [R01] [R02] system clock stops
      sysclk_run_out    <= !mode_stops_sysclk(mode_d);
      // [R01] timebase stops in sleep
      timebase_run_out  <= (mode_d != MODE_SLEEP);
      // [R04] [R12] sub clock stays on
      sub_osc_en_out    <= low_run || low_volt_detect_enable_q;
      high_osc_en_out   <= high_osc_en_d;
      // [R08] divided outputs follow oscillator
      high_div_en_out   <= high_osc_en_d;
      // [R05] [R06] divider select
      sysclk_is_sub_out   <= sysclk_is_sub_d;
      high_div_onehot_out <= high_osc_en_d ? (want_sub ? 7'h01 : want_div) : 7'h00;
      // [R12] detector kept active
      lvd_active_out      <= low_volt_detect_enable_q;
    end
  end

  // ==========================================================================
  // Register read port
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        // [R11] unimplemented bits zero
        `ADDR_SYSTEM_MODE_CONTROL:
          rdata_out <= {clk_sel_q, 1'b0, low_osc_ready, high_osc_ready, idle_enable_q, high_clock_select_q};
        `ADDR_POWER_CONTROL_FLAGS:
          rdata_out <= {idle_sysclk_keep_q, 4'h0, reset_flags_q};
        `ADDR_MODE_STATUS:
          rdata_out <= {2'h0, mode_q, 2'h0, low_volt_detect_enable_q};
        default:
          rdata_out <= 8'h00;
      endcase
    end
    else
      rdata_out <= 8'h00;
  end

endmodule

`default_nettype wire

// ---- tb/mode_clock_ctrl_asserts.sv ----
// Checker for the mode and clock controller, watching its ports only.
// Assumes it is bound to the top module and shares its clock and reset.
`default_nettype none
module mode_clock_ctrl_asserts (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic [1:0] addr_in,
  input wire logic       rd_in,
  input wire logic       halt_in,
  input wire logic       wake_in,
  input wire logic [7:0] rdata_out,
  input wire logic       cpu_run_out,
  input wire logic       sysclk_run_out,
  input wire logic       timebase_run_out,
  input wire logic       sub_osc_en_out,
  input wire logic       high_osc_en_out,
  input wire logic       high_div_en_out,
  input wire logic       sysclk_is_sub_out,
  input wire logic [6:0] high_div_onehot_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_q;
  logic       live;
  // Outputs are held at zero for two edges after reset release.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      age_q <= 2'h0;
    else if (age_q != 2'h3)
      age_q <= age_q + 2'h1;
  end
  assign live = (age_q == 2'h3);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ==========================================================================
  // Assertions
  AST_DIV_FOLLOWS: assert property (high_div_en_out == high_osc_en_out &&
                                    (high_div_onehot_out != 7'h00) == high_osc_en_out)
    else $error("divided clock enable differs from oscillator enable");
  AST_DIV_ONEHOT: assert property ($onehot0(high_div_onehot_out))
    else $error("more than one divider selected");
  AST_DIV_OFF: assert property (!high_osc_en_out |-> high_div_onehot_out == 7'h00)
    else $error("divided clock runs with oscillator stopped");
  AST_SUB_RUNS: assert property (live |-> sub_osc_en_out)
    else $error("sub oscillator stopped");
  AST_HALT_STOPS: assert property (live && halt_in && cpu_run_out |-> ##3 !cpu_run_out)
    else $error("halt did not stop the cpu");
  AST_WAKE_RUNS: assert property (live && wake_in && !cpu_run_out |-> ##2 cpu_run_out)
    else $error("wake did not restart the cpu");
  AST_OSC_STOPS: assert property (live && !sysclk_run_out |-> !high_osc_en_out)
    else $error("high oscillator runs with system clock stopped");
  AST_TB_SLEEP: assert property (live && !timebase_run_out |-> !sysclk_run_out && !cpu_run_out)
    else $error("timebase stopped outside sleep");
  AST_SLOW_OFF: assert property (live && cpu_run_out && sysclk_is_sub_out |-> !high_osc_en_out)
    else $error("high oscillator runs in slow mode");
  AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  AST_SMC_GAP: assert property (rd_in && addr_in == 2'h0 |=> !rdata_out[4])
    else $error("mode register bit 4 not zero");
  AST_PCF_GAP: assert property (rd_in && addr_in == 2'h1 |=> rdata_out[6:3] == 4'h0)
    else $error("control register bits 6 to 3 not zero");
  cover property (live && halt_in && cpu_run_out);
  cover property (live && wake_in && !cpu_run_out);
  cover property (live && cpu_run_out && sysclk_is_sub_out);
endmodule
`default_nettype wire

// ---- tb/core_model.sv ----
// Processor core stand-in that issues halt and wake pulses.
// Assumes one-cycle pulses launched right after a rising edge.
`default_nettype none
module core_model (
  input  wire logic clk_in,
  output var  logic halt_out,
  output var  logic wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    halt_out = 1'b0;
    wake_out = 1'b0;
  end
  task automatic pulse(input logic is_wake);
    @(posedge clk_in);
    halt_out <= !is_wake;
    wake_out <= is_wake;
    @(posedge clk_in);
    halt_out <= 1'b0;
    wake_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/mode_clock_ctrl_tb.sv ----
// Self-checking bench for the mode and clock controller.
// Assumes a 100 MHz clock and a core model driving halt and wake.
`default_nettype none
module mode_clock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, reset_n_in, wr_in, rd_in, halt_in, wake_in;
  logic [1:0]  addr_in;
  logic [7:0]  wdata_in, rdata_out, rd_q;
  logic [6:0]  onehot;
  logic        cpu, sys, tbr, sub, hi, div, is_sub, lvd;
  int          failures, num_checks, n;
  logic [15:0] rows [9] = '{16'hC301, 16'h0280, 16'h4240, 16'h2280, 16'h6220, 16'h8210, 16'hA208, 16'hC204,
                            16'hE202};
  mode_clock_ctrl dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .halt_in(halt_in), .wake_in(wake_in), .rdata_out(rdata_out),
    .cpu_run_out(cpu), .sysclk_run_out(sys), .timebase_run_out(tbr), .sub_osc_en_out(sub),
    .high_osc_en_out(hi), .high_div_en_out(div), .sysclk_is_sub_out(is_sub),
    .high_div_onehot_out(onehot), .lvd_active_out(lvd));
  core_model core (.clk_in(clk_in), .halt_out(halt_in), .wake_out(wake_in));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1 rd_q = rdata_out;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic stop_test();
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {reset_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    failures = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    bus(0, 2'h0, 8'h00);
    check("mode reg reset", rd_q & 8'hF3, 8'hC2);
    bus(0, 2'h1, 8'h00);
    check("control reset", rd_q, 8'h00);
    idle(20);
    bus(0, 2'h0, 8'h00);
    check("ready flags", rd_q, 8'hCE);
    bus(1, 2'h1, 8'hFF);
    bus(0, 2'h1, 8'h00);
    check("control bits", rd_q, 8'h87);
    bus(1, 2'h0, 8'hDE);
    bus(0, 2'h0, 8'h00);
    check("mode reg bits", rd_q, 8'hCE);
    bus(1, 2'h3, 8'hFF);
    bus(0, 2'h3, 8'h00);
    check("unmapped", rd_q, 8'h00);
    foreach (rows[i])
    begin
      bus(1, 2'h0, rows[i][15:8]);
      idle(20);
      check("divider", onehot, rows[i][6:0]);
      check("sub select", is_sub, rows[i][7]);
      check("high osc", hi, !rows[i][7]);
      check("divided enable", div, !rows[i][7]);
    end
    for (int m = 0; m < 3; m++)
    begin
      bus(1, 2'h0, m ? 8'hC2 : 8'hC0);
      bus(1, 2'h1, {m == 2, 7'h00});
      bus(1, 2'h2, {7'h00, m == 1});
      core.pulse(0);
      bus(1, 2'h0, 8'hC2);
      core.pulse(0);
      idle(3);
      check("cpu", cpu, 1'b0);
      check("sysclk", sys, m == 2);
      check("timebase", tbr, m != 0);
      check("sub osc", sub, 1'b1);
      check("detector", lvd, m == 1);
      bus(0, 2'h0, 8'h00);
      check("high ready", rd_q[2], m == 2);
      core.pulse(1);
      n = 0;
      do
      begin
        bus(0, 2'h0, 8'h00);
        n++;
      end
      while (rd_q[2] !== 1'b1 && n < 40);
      if (n == 40)
      begin
        failures++;
        break;
      end
      if (m < 2)
        check("ready delay", n >= 8 && n <= 9, 1'b1);
      idle(4);
      check("cpu after wake", cpu, 1'b1);
    end
    // Idle_clock_running_mode taken from slow mode keeps the sub clock as system clock.
    bus(1, 2'h0, 8'h02);
    idle(4);
    core.pulse(0);
    idle(3);
    check("idle_clock_running_mode sub", is_sub, 1'b1);
    check("idle_clock_running_mode high", hi, 1'b0);
    check("idle_clock_running_mode sysclk", sys, 1'b1);
    core.pulse(1);
    idle(2);
    check("slow after wake", is_sub & cpu, 1'b1);
    // Reset in mid-run puts every register back to its reset value.
    bus(1, 2'h0, 8'h03);
    bus(1, 2'h2, 8'h01);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    bus(0, 2'h0, 8'h00);
    check("mode reg after reset", rd_q, 8'hCA);
    bus(0, 2'h1, 8'h00);
    check("control after reset", rd_q, 8'h00);
    bus(0, 2'h2, 8'h00);
    check("status after reset", rd_q, 8'h00);
    check("detector after reset", lvd, 1'b0);
    stop_test();
  end
endmodule
bind mode_clock_ctrl mode_clock_ctrl_asserts chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
  .rd_in(rd_in), .halt_in(halt_in), .wake_in(wake_in), .rdata_out(rdata_out), .cpu_run_out(cpu_run_out),
  .sysclk_run_out(sysclk_run_out), .timebase_run_out(timebase_run_out), .sub_osc_en_out(sub_osc_en_out),
  .high_osc_en_out(high_osc_en_out), .high_div_en_out(high_div_en_out), .sysclk_is_sub_out(sysclk_is_sub_out),
  .high_div_onehot_out(high_div_onehot_out));
`default_nettype wire
